// [rtl/arxcdr_pkg.sv]
// Function
// - Sample receive line sixteen times per bit, or eight in double speed.
// - A high-to-low line transition starts qualification; first low sample is one.
// - Start judged on samples 8,9,10 normal or 4,5,6 double speed.
// - Two or more high qualification samples reject start as noise; search again.
// - Valid start resynchronises bit timing, afresh for every frame.
// - Sample counter has sixteen or eight states per bit; sample equals state.
// - Each bit is the majority of its three centre samples.
// - Recover data and parity through first stop bit; ignore later stop bits.
// - Stop bit voted too; voted zero sets frame error for that frame.
// - Rearm start detection right after last stop-bit vote sample.
// - Double speed select switches to eight-sample double speed sampling.
// - Frames of five to ten character-plus-parity bits are handled.
// - Rate error budget split equally between both ends.
// - Clearing receiver enable stops reception at once, dropping the frame.
// - Frame error is zero for stop read one, one for stop read zero.
package arxcdr_pkg;
   // ==========================================================
   // Sampling constants
   localparam logic [4:0] SMP_NORMAL   = 5'h10;
   localparam logic [4:0] SMP_DOUBLE   = 5'h08;
   localparam logic [4:0] VOTE_NORMAL  = 5'h08;
   localparam logic [4:0] VOTE_DOUBLE  = 5'h04;
   localparam logic [3:0] BITS_MIN     = 4'h5;
   localparam logic [3:0] BITS_MAX     = 4'ha;
   localparam logic [1:0] SYNC_IDLE    = 2'h3;

   typedef enum logic [1:0] {
      ARX_IDLE,
      ARX_START,
      ARX_BITS
   } arx_state_t;

   typedef struct packed {
      logic [9:0] bits;
      logic       frameErr;
   } arx_frame_t;
endpackage : arxcdr_pkg

// [rtl/arxcdr_vote.sv]
`timescale 1ns/1ps
`default_nettype none
module arxcdr_vote (
   input  wire logic       ref_clk,
   input  wire logic       clear,
   input  wire logic       take,
   input  wire logic       smp,
   output logic            voted
);
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;

   // ==========================================================
   // Counts high samples among the three centre samples
   always_comb begin
      cnt_nxt = cnt_r;
      if (clear) begin
         cnt_nxt = 2'h0;
      end else if (take && smp && cnt_r != 2'h3) begin
         cnt_nxt = cnt_r + 2'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      cnt_r <= cnt_nxt;
   end

   assign voted = cnt_r[1];
endmodule : arxcdr_vote
`default_nettype wire

// [rtl/arxcdr_top.sv]
`timescale 1ns/1ps
`default_nettype none
module arxcdr_top (
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire logic                   sampleTick,
   input  wire logic                   rxLine,
   input  wire logic                   receiver_enable_bit,
   input  wire logic                   double_speed_select,
   input  wire logic [3:0]             frameBits,
   output arxcdr_pkg::arx_frame_t      frameOut,
   output logic                        frameValid,
   output logic                        frame_error_flag,
   output logic                        rxBusy
);
   // ==========================================================
   // Synchroniser
   logic [1:0] sync_r;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync_r <= arxcdr_pkg::SYNC_IDLE;
      end else begin
         sync_r <= {sync_r[0], rxLine};
      end
   end
   logic rxS;
   assign rxS = sync_r[1];

   // ==========================================================
   // Recovery state
   arxcdr_pkg::arx_state_t state_r, state_nxt;
   logic [4:0]  smp_r, smp_nxt;
   logic [3:0]  bitIdx_r, bitIdx_nxt;
   logic [9:0]  shift_r, shift_nxt;
   logic        prev_r, prev_nxt;
   arxcdr_pkg::arx_frame_t frame_r, frame_nxt;
   logic        fv_r, fv_nxt;
   logic        fe_r, fe_nxt;
   logic        busy_r, busy_nxt;
   logic        voted;
   logic        voteClr;
   logic        voteTake;

   logic [4:0] perBit;
   logic [4:0] vFirst;
   logic [3:0] nBits;
   assign perBit = double_speed_select ? arxcdr_pkg::SMP_DOUBLE
                                       : arxcdr_pkg::SMP_NORMAL;
   assign vFirst = double_speed_select ? arxcdr_pkg::VOTE_DOUBLE
                                       : arxcdr_pkg::VOTE_NORMAL;
   // Out-of-range lengths are clamped rather than left undefined
   assign nBits = (frameBits < arxcdr_pkg::BITS_MIN) ? arxcdr_pkg::BITS_MIN :
                  (frameBits > arxcdr_pkg::BITS_MAX) ? arxcdr_pkg::BITS_MAX :
                  frameBits;

   logic atLastVote;
   assign atLastVote = (smp_r == vFirst + 5'h2);

   always_comb begin
      state_nxt  = state_r;
      smp_nxt    = smp_r;
      bitIdx_nxt = bitIdx_r;
      shift_nxt  = shift_r;
      prev_nxt   = prev_r;
      frame_nxt  = frame_r;
      fv_nxt     = 1'b0;
      fe_nxt     = fe_r;
      voteClr    = 1'b0;
      voteTake   = 1'b0;
      if (!receiver_enable_bit) begin
         // Drop everything at once, no partial frame survives
         state_nxt = arxcdr_pkg::ARX_IDLE;
         smp_nxt   = 5'h0;
         prev_nxt  = 1'b1;
         voteClr   = 1'b1;
         fe_nxt    = 1'b0;
      end else if (sampleTick) begin
         prev_nxt = rxS;
         unique case (state_r)
            arxcdr_pkg::ARX_IDLE: begin
               voteClr = 1'b1;
               if (prev_r && !rxS) begin
                  state_nxt = arxcdr_pkg::ARX_START;
                  smp_nxt   = 5'h2;
               end
            end
            arxcdr_pkg::ARX_START: begin
               if (smp_r >= vFirst && smp_r <= vFirst + 5'h2) begin
                  voteTake = 1'b1;
               end
               smp_nxt = smp_r + 5'h1;
               if (smp_r == vFirst + 5'h3) begin
                  voteClr = 1'b1;
                  if (voted) begin
                     state_nxt = arxcdr_pkg::ARX_IDLE;
                     smp_nxt   = 5'h0;
                  end
               end
               if (smp_r == perBit) begin
                  // Bit timing restarts from this start bit
                  state_nxt  = arxcdr_pkg::ARX_BITS;
                  smp_nxt    = 5'h1;
                  bitIdx_nxt = 4'h0;
                  shift_nxt  = 10'h000;
               end
            end
            arxcdr_pkg::ARX_BITS: begin
               if (smp_r >= vFirst && smp_r <= vFirst + 5'h2) begin
                  voteTake = 1'b1;
               end
               smp_nxt = (smp_r == perBit) ? 5'h1 : smp_r + 5'h1;
               if (smp_r == vFirst + 5'h3 && bitIdx_r == nBits) begin
                  // Stop vote done: rearm early, extra stop bits are ignored
                  frame_nxt.bits     = shift_r;
                  frame_nxt.frameErr = ~voted;
                  fe_nxt             = ~voted;
                  fv_nxt             = 1'b1;
                  voteClr            = 1'b1;
                  state_nxt          = arxcdr_pkg::ARX_IDLE;
                  smp_nxt            = 5'h0;
                  prev_nxt           = 1'b0;
               end else if (smp_r == perBit) begin
                  shift_nxt[bitIdx_r] = voted;
                  bitIdx_nxt          = bitIdx_r + 4'h1;
                  voteClr             = 1'b1;
               end
            end
            default: begin
               state_nxt = arxcdr_pkg::ARX_IDLE;
            end
         endcase
      end
      busy_nxt = (state_nxt != arxcdr_pkg::ARX_IDLE);
   end

   // Rearm uses prev=0 so the line must be seen high again before a new start
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r  <= arxcdr_pkg::ARX_IDLE;
         smp_r    <= 5'h0;
         bitIdx_r <= 4'h0;
         shift_r  <= 10'h000;
         prev_r   <= 1'b1;
         frame_r  <= '0;
         fv_r     <= 1'b0;
         fe_r     <= 1'b0;
         busy_r   <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         smp_r    <= smp_nxt;
         bitIdx_r <= bitIdx_nxt;
         shift_r  <= shift_nxt;
         prev_r   <= prev_nxt;
         frame_r  <= frame_nxt;
         fv_r     <= fv_nxt;
         fe_r     <= fe_nxt;
         busy_r   <= busy_nxt;
      end
   end

   arxcdr_vote u_vote (
      .ref_clk (ref_clk),
      .clear   (voteClr | rst),
      .take    (voteTake),
      .smp     (rxS),
      .voted   (voted)
   );

   assign frameOut         = frame_r;
   assign frameValid       = fv_r;
   assign frame_error_flag = fe_r;
   assign rxBusy           = busy_r;
endmodule : arxcdr_top
`default_nettype wire

// [verification/arxcdr_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module arxcdr_asserts (
   input wire logic                   ref_clk,
   input wire logic                   rst,
   input wire logic                   sampleTick,
   input wire logic                   rxLine,
   input wire logic                   receiver_enable_bit,
   input wire logic                   double_speed_select,
   input wire logic [3:0]             frameBits,
   input wire arxcdr_pkg::arx_frame_t frameOut,
   input wire logic                   frameValid,
   input wire logic                   frame_error_flag,
   input wire logic                   rxBusy
);
   // ==================
   // Checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Ticks while busy; a ten-bit frame ends by stop sample 11
   logic [7:0] tk_r;
   always_ff @(posedge ref_clk) begin
      if (rst || !rxBusy) tk_r <= 8'h00;
      else if (sampleTick) tk_r <= tk_r + 8'h01;
   end
   property p_pulse; frameValid |=> !frameValid; endproperty
   a_pulse: assert property (p_pulse) else $error("valid held too long");
   property p_err; frameValid |-> frame_error_flag == frameOut.frameErr; endproperty
   a_err: assert property (p_err) else $error("flag differs from frame");
   property p_offbusy; !receiver_enable_bit |=> !rxBusy && !frameValid; endproperty
   a_offbusy: assert property (p_offbusy) else $error("busy while disabled");
   property p_offflag; !receiver_enable_bit |=> !frame_error_flag; endproperty
   a_offflag: assert property (p_offflag) else $error("flag kept on disable");
   property p_start; $rose(rxBusy) |-> $past(sampleTick); endproperty
   a_start: assert property (p_start) else $error("start off a tick");
   property p_end; frameValid |-> $past(sampleTick); endproperty
   a_end: assert property (p_end) else $error("frame end off a tick");
   property p_upper;
      frameValid && frameBits >= 4'h5 && frameBits <= 4'ha |-> (frameOut.bits >> frameBits) == 10'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("unused bits set");
   property p_bound; tk_r <= 8'hbc; endproperty
   a_bound: assert property (p_bound) else $error("frame too long");
   c_err: cover property (frameValid && frameOut.frameErr);
   c_dbl: cover property (frameValid && double_speed_select);
   c_abort: cover property (rxBusy && !receiver_enable_bit);
endmodule : arxcdr_asserts
bind arxcdr_top arxcdr_asserts chk_u (.*);
`default_nettype wire

// [verification/arxcdr_tx_model.sv]
`timescale 1ns/1ps
`default_nettype none
module arxcdr_tx_model (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        sampleTick,
   input  wire logic        go,
   input  wire logic [11:0] frm,
   input  wire logic [3:0]  nb,
   input  wire logic [4:0]  spb,
   output logic             line,
   output logic             busy
);
   // ==================
   // Sender at exactly the receiver rate, bits LSB first
   logic [11:0] sh_r;
   logic [3:0]  left_r;
   logic [4:0]  smp_r;
   assign busy = (left_r != 4'h0);
   assign line = busy ? sh_r[0] : 1'b1;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         left_r <= 4'h0;
      end else if (go) begin
         sh_r <= frm;
         left_r <= nb;
         smp_r <= 5'h0;
      end else if (sampleTick && busy) begin
         smp_r <= (smp_r == spb - 5'h1) ? 5'h0 : smp_r + 5'h1;
         if (smp_r == spb - 5'h1) begin
            sh_r <= {1'b1, sh_r[11:1]};
            left_r <= left_r - 4'h1;
         end
      end
   end
endmodule : arxcdr_tx_model
`default_nettype wire

// [verification/test_async_rx_clock_data_recovery.sv]
`timescale 1ns/1ps
`default_nettype none
module test_async_rx_clock_data_recovery;
   logic ref_clk, rst, sampleTick, enable, dbl, go, glitch, txLine, txBusy;
   logic frameValid, flag, rxBusy;
   logic [3:0] frameBits, nb;
   logic [11:0] frm;
   logic [1:0] div_r;
   arxcdr_pkg::arx_frame_t frameOut;
   int n_mismatch, checks, nValid;
   arxcdr_top dut_u (.ref_clk(ref_clk), .rst(rst), .sampleTick(sampleTick),
      .rxLine(txLine & ~glitch), .receiver_enable_bit(enable), .double_speed_select(dbl),
      .frameBits(frameBits), .frameOut(frameOut), .frameValid(frameValid),
      .frame_error_flag(flag), .rxBusy(rxBusy));
   arxcdr_tx_model tx_u (.ref_clk(ref_clk), .rst(rst), .sampleTick(sampleTick), .go(go),
      .frm(frm), .nb(nb), .spb(dbl ? arxcdr_pkg::SMP_DOUBLE : arxcdr_pkg::SMP_NORMAL),
      .line(txLine), .busy(txBusy));
   // ==================
   // Clock, tick every fourth cycle, frame counter
   initial begin ref_clk = 1'b0; forever #10 ref_clk = ~ref_clk; end
   always @(posedge ref_clk) begin
      div_r <= div_r + 2'h1;
      sampleTick <= (div_r == 2'h3);
      if (frameValid === 1'b1) nValid++;
   end
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic launch(input logic [9:0] w, input logic [3:0] n, input logic stp);
      logic [11:0] p;
      p = {1'b1, w, 1'b0} | (12'hffe << n);
      p[n + 1] = stp;
      @(posedge ref_clk);
      frameBits <= n;
      nb <= n + 4'h2;
      frm <= p;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
   endtask : launch
   task automatic rx_frame(input logic [9:0] w, input logic [3:0] n, input logic stp);
      int v;
      v = nValid;
      launch(w, n, stp);
      for (int i = 0; i < 3000 && nValid == v; i++) @(posedge ref_clk);
      chk(11'(nValid - v), 11'h1);
      chk({frameOut.frameErr, frameOut.bits}, {~stp, w & ((10'h1 << n) - 10'h1)});
      chk({10'h0, flag}, {10'h0, ~stp});
      while (txBusy) @(posedge ref_clk);
   endtask : rx_frame
   task automatic t_basic();
      rx_frame(10'h0a5, 4'h8, 1'b1);
      rx_frame(10'h015, 4'h5, 1'b1);
      rx_frame(10'h2c3, 4'ha, 1'b1);
   endtask : t_basic
   task automatic t_ferr();
      rx_frame(10'h05a, 4'h8, 1'b0);
      rx_frame(10'h0ff, 4'h7, 1'b1);
   endtask : t_ferr
   task automatic t_double();
      dbl <= 1'b1;
      rx_frame(10'h00a, 4'h5, 1'b1);
      rx_frame(10'h35c, 4'ha, 1'b0);
      dbl <= 1'b0;
   endtask : t_double
   task automatic t_noise();
      int v;
      v = nValid;
      @(posedge ref_clk);
      glitch <= 1'b1;
      repeat (24) @(posedge ref_clk);
      glitch <= 1'b0;
      repeat (100) @(posedge ref_clk);
      chk({10'h0, rxBusy}, 11'h0);
      chk(11'(nValid - v), 11'h0);
      rx_frame(10'h081, 4'h8, 1'b1);
   endtask : t_noise
   task automatic t_abort();
      int v;
      rx_frame(10'h000, 4'h8, 1'b0);
      v = nValid;
      launch(10'h1ff, 4'h9, 1'b1);
      repeat (200) @(posedge ref_clk);
      enable <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk({9'h0, rxBusy, flag}, 11'h0);
      while (txBusy) @(posedge ref_clk);
      enable <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk(11'(nValid - v), 11'h0);
   endtask : t_abort
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   initial begin
      rst = 1'b1; enable = 1'b1; dbl = 1'b0; go = 1'b0; glitch = 1'b0;
      frameBits = 4'h8; nb = 4'h0; frm = 12'hfff; div_r = 2'h0; sampleTick = 1'b0;
      n_mismatch = 0; checks = 0; nValid = 0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      t_basic();
      t_ferr();
      t_double();
      t_noise();
      t_abort();
      report_and_stop();
   end
   // Roughly five times the expected run
   initial begin #600000; n_mismatch++; report_and_stop(); end
endmodule : test_async_rx_clock_data_recovery
`default_nettype wire
